// file: core/e1ae_pkg.sv
// constants shared by the receive alarm and error status block
// Notes on behaviour
// - status bit 7 shows live out-of-frame state
// - out-of-frame after criteria-count errored alignment patterns
// - all-ones defect declared after two frames
// - all-ones defect cleared after two zero-rich frames
// - status bit 5 flags CAS yellow change
// - CAS yellow follows received y bit
// - status bit 4 shows live signal loss
// - signal loss declared after 175 bits
// - signal loss clears on absence or density
// - status bit 3 flags line code errors
// - out-of-frame change sets its flag
// - status bit 1 flags all-ones change
// - change flags clear when status is read
// - interrupt only with source enable set
// - block enable low suppresses every interrupt
// - status bit 0 flags remote alarm change
// - remote alarm follows two matching A bits
package e1ae_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CRIT = 8'h0C;
  localparam int B_OOF = 7;
  localparam int B_AIS = 6;
  localparam int B_MYEL = 5;
  localparam int B_LOS = 4;
  localparam int B_LCV = 3;
  localparam int B_OOFC = 2;
  localparam int B_AISC = 1;
  localparam int B_YELC = 0;
  localparam int B_BLK = 0;
  localparam int CRIT_W = 3;
  localparam logic [7:0] CHG_MASK = 8'h2F;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [CRIT_W-1:0] CRIT_RST = 3'h3;
  localparam int LOS_BITS = 175;
  localparam int LOS_MIN_ONES = (LOS_BITS + 7) / 8;
  localparam int AIS_FRAMES = 2;
  localparam int AIS_MAX_ZEROS = 2;
  localparam int YEL_FRAMES = 2;
endpackage

// file: core/e1ae_persist.sv
// counter of consecutive qualifying samples with a run threshold
`timescale 1ns/1ps
module e1ae_persist #(
  parameter int W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hit,
  input wire logic miss,
  input wire logic [W-1:0] thresh,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } e1ae_pst_t;

  e1ae_pst_t q;
  e1ae_pst_t d;

  if (W < 1) begin : g_chk
    $error("e1ae_persist: W must be at least 1");
  end

  // the run is complete when this hit brings the count to the threshold
  assign done = hit && (({1'b0, q.cnt} + {{W{1'b0}}, 1'b1}) >= {1'b0, thresh});

  // a miss breaks the run; the count holds once the run is complete
  always_comb begin
    d = q;
    if (miss) begin
      d.cnt = '0;
    end else if (hit && !done) begin
      d.cnt = q.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// file: core/e1ae_status.sv
// receive alarm and error status, change flags, enables and apb access
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module e1ae_status #(
  parameter int LOS_N = e1ae_pkg::LOS_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [e1ae_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  input wire logic frame_end,
  input wire logic fas_strobe,
  input wire logic fas_errored,
  input wire logic nfas_strobe,
  input wire logic a_bit,
  input wire logic mf_strobe,
  input wire logic y_bit,
  input wire logic lcv_pulse,
  input wire logic los_cond
);
  import e1ae_pkg::*;

  localparam int CW = $clog2(LOS_N + 1);
  localparam logic [CW-1:0] LOS_LAST = CW'(LOS_N - 1);
  localparam logic [CW-1:0] LOS_THR = CW'(LOS_N);
  localparam logic [CW-1:0] ONES_MIN = CW'((LOS_N + 7) / 8);
  localparam logic [1:0] AIS_THR = 2'(AIS_FRAMES);
  localparam logic [1:0] YEL_THR = 2'(YEL_FRAMES);
  localparam logic [1:0] ZMAX = 2'(AIS_MAX_ZEROS);

  if (LOS_N < 8) begin : g_chk
    $error("e1ae_status: LOS_N too small for the density window");
  end

  typedef struct packed {
    logic [2:0] los_sync;
    logic los_s;
    logic oof;
    logic ais;
    logic my;
    logic los;
    logic yel;
    logic [7:0] flag;
    logic [7:0] en;
    logic blk;
    logic [CRIT_W-1:0] crit;
    logic [1:0] zcnt;
    logic [CW-1:0] win_bits;
    logic [CW-1:0] win_ones;
    logic [31:0] rdata;
    logic slverr;
  } e1ae_state_t;

  e1ae_state_t q;
  e1ae_state_t d;

  logic setup;
  logic access;
  logic rd_status;
  logic oof_done;
  logic ais_set;
  logic ais_clr;
  logic yel_set;
  logic yel_clr;
  logic los_done;
  logic dens_ok;
  logic zero_rich;
  logic [CRIT_W-1:0] crit_eff;
  logic [CW-1:0] ones_sum;
  logic [7:0] status_v;
  logic [7:0] events;

  // zero-wait slave: every access phase completes in its first cycle
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = access && q.slverr;
  assign rd_status = access && !pwrite && (paddr == OFF_STATUS);

  // a zero criteria acts as one: the first errored pattern declares
  assign crit_eff = (q.crit == '0) ? CRIT_W'(1) : q.crit;

  // a frame counts as zero-rich with more than two zeros in it
  assign zero_rich = q.zcnt > ZMAX;

  // errored alignment run against the programmed criteria
  e1ae_persist #(.W(CRIT_W)) u_oof (
    .pclk(pclk),
    .presetn(presetn),
    .hit(fas_strobe && fas_errored),
    .miss(fas_strobe && !fas_errored),
    .thresh(crit_eff),
    .done(oof_done)
  );

  // all-ones frames toward declaring the defect
  e1ae_persist #(.W(2)) u_ais_set (
    .pclk(pclk),
    .presetn(presetn),
    .hit(frame_end && !zero_rich),
    .miss(frame_end && zero_rich),
    .thresh(AIS_THR),
    .done(ais_set)
  );

  // zero-rich frames toward clearing the defect
  e1ae_persist #(.W(2)) u_ais_clr (
    .pclk(pclk),
    .presetn(presetn),
    .hit(frame_end && zero_rich),
    .miss(frame_end && !zero_rich),
    .thresh(AIS_THR),
    .done(ais_clr)
  );

  // remote alarm needs two matching A bits either way
  e1ae_persist #(.W(2)) u_yel_set (
    .pclk(pclk),
    .presetn(presetn),
    .hit(nfas_strobe && a_bit),
    .miss(nfas_strobe && !a_bit),
    .thresh(YEL_THR),
    .done(yel_set)
  );

  e1ae_persist #(.W(2)) u_yel_clr (
    .pclk(pclk),
    .presetn(presetn),
    .hit(nfas_strobe && !a_bit),
    .miss(nfas_strobe && a_bit),
    .thresh(YEL_THR),
    .done(yel_clr)
  );

  // consecutive bit periods with the loss condition present
  // a dense window restarts the run, so a new declare needs a fresh full run
  e1ae_persist #(.W(CW)) u_los (
    .pclk(pclk),
    .presetn(presetn),
    .hit(rx_bit_en && q.los_s),
    .miss(!q.los_s || dens_ok),
    .thresh(LOS_THR),
    .done(los_done)
  );

  // density check closes at the last bit of each window
  assign ones_sum = q.win_ones + {{(CW-1){1'b0}}, rx_bit};
  assign dens_ok = q.los && rx_bit_en && (q.win_bits == LOS_LAST) && (ones_sum >= ONES_MIN);

  // live view of the status register
  always_comb begin
    status_v = q.flag & CHG_MASK;
    status_v[B_OOF] = q.oof;
    status_v[B_AIS] = q.ais;
    status_v[B_LOS] = q.los;
  end

  always_comb begin
    d = q;
    events = 8'h00;

    // loss condition comes from the line side, so it is resynchronised
    d.los_sync = {q.los_sync[1:0], los_cond};
    if (q.los_sync[1] == q.los_sync[2]) begin
      d.los_s = q.los_sync[2];
    end

    // zeros per frame, saturating; a bit in the frame_end cycle opens the next frame
    if (frame_end) begin
      d.zcnt = (rx_bit_en && !rx_bit) ? 2'h1 : 2'h0;
    end else if (rx_bit_en && !rx_bit && q.zcnt != 2'h3) begin
      d.zcnt = q.zcnt + 2'h1;
    end

    // out-of-frame leaves on the first good alignment pattern
    if (oof_done) begin
      d.oof = 1'b1;
    end else if (fas_strobe && !fas_errored) begin
      d.oof = 1'b0;
    end

    if (ais_set) begin
      d.ais = 1'b1;
    end else if (ais_clr) begin
      d.ais = 1'b0;
    end

    if (yel_set) begin
      d.yel = 1'b1;
    end else if (yel_clr) begin
      d.yel = 1'b0;
    end

    if (mf_strobe) begin
      d.my = y_bit;
    end

    // absence of the condition wins over everything else
    // the saturated run count would re-declare at once, so density goes first
    if (!q.los_s) begin
      d.los = 1'b0;
    end else if (dens_ok) begin
      d.los = 1'b0;
    end else if (los_done) begin
      d.los = 1'b1;
    end

    // density window runs only while loss is declared
    if (!q.los) begin
      d.win_bits = '0;
      d.win_ones = '0;
    end else if (rx_bit_en) begin
      if (q.win_bits == LOS_LAST) begin
        d.win_bits = '0;
        d.win_ones = '0;
      end else begin
        d.win_bits = q.win_bits + {{(CW-1){1'b0}}, 1'b1};
        d.win_ones = ones_sum;
      end
    end

    // register writes; only byte lane 0 carries bits
    if (access && pwrite && pstrb[0]) begin
      case (paddr)
        OFF_STATUS: d.flag = q.flag & ~(pwdata[7:0] & CHG_MASK);
        OFF_ENABLE: d.en = pwdata[7:0] & CHG_MASK;
        OFF_CTRL: d.blk = pwdata[B_BLK];
        OFF_CRIT: d.crit = pwdata[CRIT_W-1:0];
        default: d.flag = d.flag;
      endcase
    end

    // only bits the reader actually saw are cleared, so late events survive
    if (rd_status) begin
      d.flag = q.flag & ~(q.rdata[7:0] & CHG_MASK);
    end

    // event flags; set wins over both clears
    events[B_MYEL] = d.my != q.my;
    events[B_LCV] = lcv_pulse;
    events[B_OOFC] = d.oof != q.oof;
    events[B_AISC] = d.ais != q.ais;
    events[B_YELC] = d.yel != q.yel;
    d.flag = d.flag | events;

    // read data and error are prepared in the setup phase
    if (setup) begin
      d.slverr = 1'b0;
      case (paddr)
        OFF_STATUS: d.rdata = {24'h000000, status_v};
        OFF_ENABLE: d.rdata = {24'h000000, q.en};
        OFF_CTRL: d.rdata = {31'h00000000, q.blk};
        OFF_CRIT: d.rdata = {29'h00000000, q.crit};
        default: begin
          d.rdata = 32'h00000000;
          d.slverr = 1'b1;
        end
      endcase
    end else if (access) begin
      d.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.en <= ENABLE_RST;
      q.blk <= CTRL_RST;
      q.crit <= CRIT_RST;
    end else begin
      q <= d;
    end
  end

  // level output, gated per source and by the block enable
  assign irq = q.blk && |(q.flag & q.en & CHG_MASK);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_oof_declare: assert property ($rose(q.oof) |-> $past(fas_strobe && fas_errored))
    else $error("out-of-frame rose without an errored pattern");
  chk_ais_timing: assert property ($changed(q.ais) |-> $past(frame_end))
    else $error("all-ones state moved off a frame boundary");
  chk_ais_clear: assert property ($fell(q.ais) |-> $past(zero_rich))
    else $error("all-ones cleared on a frame without zeros");
  chk_cas_follow: assert property (mf_strobe |=> q.my == $past(y_bit))
    else $error("cas yellow does not follow the y bit");
  chk_cas_flag: assert property ($changed(q.my) |-> q.flag[B_MYEL])
    else $error("cas yellow change not flagged");
  chk_lcv_flag: assert property (lcv_pulse |=> q.flag[B_LCV])
    else $error("line code error not flagged");
  chk_oof_flag: assert property ($changed(q.oof) |-> q.flag[B_OOFC])
    else $error("out-of-frame change not flagged");
  chk_ais_flag: assert property ($changed(q.ais) |-> q.flag[B_AISC])
    else $error("all-ones change not flagged");
  chk_yel_flag: assert property ($changed(q.yel) |-> q.flag[B_YELC])
    else $error("remote alarm change not flagged");
  chk_yel_pair: assert property ($rose(q.yel) |-> $past(nfas_strobe && a_bit))
    else $error("remote alarm rose without an A bit");
  chk_los_declare: assert property ($rose(q.los) |-> $past(q.los_s && rx_bit_en))
    else $error("signal loss rose without the condition");
  chk_los_absent: assert property (!q.los_s |=> !q.los)
    else $error("signal loss held while condition absent");
  chk_read_clear: assert property (rd_status && q.rdata[B_LCV] && !lcv_pulse |=> !q.flag[B_LCV])
    else $error("lcv flag survived a status read");
  chk_state_read: assert property (setup && !pwrite && paddr == OFF_STATUS |=>
    prdata[B_OOF] == $past(q.oof) && prdata[B_LOS] == $past(q.los))
    else $error("status read does not show live state");
  chk_irq_block: assert property (!q.blk |-> !irq)
    else $error("interrupt with block enable low");
  chk_irq_source: assert property (irq |-> |(q.flag & q.en))
    else $error("interrupt without an enabled flag");

  // declare and clear paths of the run counters, and flags that may only fall on access
  chk_los_density: assert property (dens_ok |=> !q.los)
    else $error("signal loss held after a dense window");
  chk_oof_leave: assert property (fas_strobe && !fas_errored |=> !q.oof)
    else $error("out-of-frame held after a good pattern");
  chk_crit_zero: assert property (q.crit == 3'h0 && fas_strobe && fas_errored |=> q.oof)
    else $error("zero criteria did not act as one");
  chk_ais_set: assert property ($rose(q.ais) |-> $past(frame_end && !zero_rich))
    else $error("all-ones declared on a frame with zeros");
  chk_flag_hold: assert property (($past(q.flag) & ~q.flag) != 8'h00 |->
    $past(access && paddr == OFF_STATUS))
    else $error("change flag fell without a status access");

  cov_oof_cycle: cover property ($rose(q.oof) ##[1:1000] $fell(q.oof));
  cov_ais_declare: cover property ($rose(q.ais));
  cov_los_dens: cover property (dens_ok);
  cov_los_declare: cover property ($rose(q.los));
  cov_irq_read: cover property (irq ##1 rd_status ##1 !irq);
endmodule

// file: verif/e1ae_line_model.sv
// behavioural model of the incoming e1 line as seen through the receive framer and liu
`timescale 1ns/1ps
module e1ae_line_model (
  input wire logic pclk,
  output logic rx_bit_en,
  output logic rx_bit,
  output logic frame_end,
  output logic fas_strobe,
  output logic fas_errored,
  output logic nfas_strobe,
  output logic a_bit,
  output logic mf_strobe,
  output logic y_bit,
  output logic lcv_pulse,
  output logic los_cond
);
  // all strobes idle at time zero
  initial begin
    {rx_bit_en, rx_bit, frame_end, fas_strobe, fas_errored} = 5'h00;
    {nfas_strobe, a_bit, mf_strobe, y_bit, lcv_pulse, los_cond} = 6'h00;
  end

  // one strobe with its qualifier; qualifiers flip once released so stale values never match
  task put(input int k, input logic v);
    @(posedge pclk);
    case (k)
      0: begin fas_strobe <= 1'b1; fas_errored <= v; end
      1: begin nfas_strobe <= 1'b1; a_bit <= v; end
      2: begin mf_strobe <= 1'b1; y_bit <= v; end
      default: lcv_pulse <= 1'b1;
    endcase
    @(posedge pclk);
    {fas_strobe, nfas_strobe, mf_strobe, lcv_pulse} <= 4'h0;
    {fas_errored, a_bit, y_bit} <= {3{~v}};
  endtask

  // short frame of eight bits, the first nz of them zero, then the frame boundary
  task frame(input int nz);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      rx_bit_en <= 1'b1;
      rx_bit <= (i >= nz);
    end
    @(posedge pclk);
    rx_bit_en <= 1'b0;
    rx_bit <= ~rx_bit;
    frame_end <= 1'b1;
    @(posedge pclk);
    frame_end <= 1'b0;
  endtask

  // n zero bits with no frame boundary, used while the signal is lost
  task bits(input int n);
    repeat (n) begin
      @(posedge pclk);
      rx_bit_en <= 1'b1;
      rx_bit <= 1'b0;
    end
    @(posedge pclk);
    rx_bit_en <= 1'b0;
    rx_bit <= 1'b1;
  endtask
endmodule

// file: verif/testbench.sv
// self-checking bench for the receive alarm and error status block
`timescale 1ns/1ps
module testbench;
  import e1ae_pkg::*;
  localparam int LN = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, irq;
  logic rx_bit_en, rx_bit, frame_end, fas_strobe, fas_errored;
  logic nfas_strobe, a_bit, mf_strobe, y_bit, lcv_pulse, los_cond;
  int n_errors = 0;
  int num_checks = 0;

  always #5 pclk = ~pclk;

  e1ae_status #(.LOS_N(LN)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .rx_bit_en(rx_bit_en),
    .rx_bit(rx_bit), .frame_end(frame_end), .fas_strobe(fas_strobe),
    .fas_errored(fas_errored), .nfas_strobe(nfas_strobe), .a_bit(a_bit),
    .mf_strobe(mf_strobe), .y_bit(y_bit), .lcv_pulse(lcv_pulse), .los_cond(los_cond));

  e1ae_line_model line (.pclk(pclk), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
    .frame_end(frame_end), .fas_strobe(fas_strobe), .fas_errored(fas_errored),
    .nfas_strobe(nfas_strobe), .a_bit(a_bit), .mf_strobe(mf_strobe), .y_bit(y_bit),
    .lcv_pulse(lcv_pulse), .los_cond(los_cond));

  task finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    n = 0;
    q = 32'h0;
    e = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      finish_test();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask

  // irq is combinational from registers, so look at it mid-cycle
  task irq_is(input logic exp);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (50000) @(posedge pclk);
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STATUS, 32'h00, 1'b0);
    rd(OFF_ENABLE, 32'h00, 1'b0);
    rd(OFF_CTRL, 32'h00, 1'b0);
    rd(OFF_CRIT, 32'h03, 1'b0);
    rd(8'h10, 32'h00, 1'b1);
    $display("test reset done");
    // criteria two: the second errored pattern declares out of frame
    wr(OFF_CRIT, 32'h02);
    line.put(0, 1'b1);
    rd(OFF_STATUS, 32'h00, 1'b0);
    line.put(0, 1'b1);
    rd(OFF_STATUS, 32'h84, 1'b0);
    rd(OFF_STATUS, 32'h80, 1'b0);
    line.put(0, 1'b0);
    rd(OFF_STATUS, 32'h04, 1'b0);
    $display("test frame loss done");
    line.frame(2);
    rd(OFF_STATUS, 32'h00, 1'b0);
    line.frame(2);
    rd(OFF_STATUS, 32'h42, 1'b0);
    line.frame(3);
    rd(OFF_STATUS, 32'h40, 1'b0);
    line.frame(3);
    rd(OFF_STATUS, 32'h02, 1'b0);
    $display("test all ones done");
    line.put(2, 1'b1);
    rd(OFF_STATUS, 32'h20, 1'b0);
    line.put(2, 1'b1);
    rd(OFF_STATUS, 32'h00, 1'b0);
    line.put(2, 1'b0);
    rd(OFF_STATUS, 32'h20, 1'b0);
    line.put(1, 1'b1);
    rd(OFF_STATUS, 32'h00, 1'b0);
    line.put(1, 1'b1);
    rd(OFF_STATUS, 32'h01, 1'b0);
    line.put(1, 1'b0);
    line.put(1, 1'b0);
    rd(OFF_STATUS, 32'h01, 1'b0);
    $display("test yellow alarms done");
    // lcv with block enable off, then on, then source masked, then read away
    wr(OFF_ENABLE, 32'hFF);
    rd(OFF_ENABLE, {24'h0, CHG_MASK}, 1'b0);
    line.put(3, 1'b1);
    irq_is(1'b0);
    wr(OFF_CTRL, 32'h01);
    irq_is(1'b1);
    wr(OFF_ENABLE, 32'h27);
    irq_is(1'b0);
    wr(OFF_ENABLE, 32'h2F);
    irq_is(1'b1);
    rd(OFF_STATUS, 32'h08, 1'b0);
    irq_is(1'b0);
    line.put(3, 1'b1);
    wr(OFF_STATUS, 32'h08);
    rd(OFF_STATUS, 32'h00, 1'b0);
    $display("test interrupts done");
    // signal loss: four flops of synchroniser and filter latency, then LN bits
    line.los_cond <= 1'b1;
    repeat (6) @(posedge pclk);
    line.bits(LN - 1);
    rd(OFF_STATUS, 32'h00, 1'b0);
    line.bits(1);
    rd(OFF_STATUS, 32'h10, 1'b0);
    line.los_cond <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(OFF_STATUS, 32'h00, 1'b0);
    $display("test signal loss done");
    finish_test();
  end
endmodule
